// *** rsq_map.vh ***
// Register map, field positions, reset values and timing constants of the reset sequencer.
`ifndef RSQ_MAP_VH
`define RSQ_MAP_VH
`define RSQ_OFS_CAUSE   12'h000
`define RSQ_OFS_SUPPLY  12'h004
`define RSQ_OFS_STATUS  12'h008
`define RSQ_B_TRAP      15
`define RSQ_B_ILLOP     14
`define RSQ_B_DSLP      10
`define RSQ_B_CM        9
`define RSQ_B_PIN       7
`define RSQ_B_SWR       6
`define RSQ_B_SW_WATCHDOG_ENABLE    5
`define RSQ_B_WATCHDOG_TIMEOUT_FLAG      4
`define RSQ_B_SLEEP     3
`define RSQ_B_IDLE      2
`define RSQ_B_BOR       1
`define RSQ_B_POR       0
`define RSQ_B_SBOR      3
`define RSQ_B_SPOR      2
`define RSQ_B_BPOR      1
`define RSQ_B_BAT       0
`define RSQ_CAUSE_RST   16'h0003
`define RSQ_CAUSE_WMASK 16'hD7FF
`define RSQ_SUPPLY_RST  4'hE
// Delays in cycles of the 25 ns clock: 10 us, 10 us, 2 us, 1 us, 5 us and 1 us.
`define RSQ_POR_CYC     16'h0190
`define RSQ_REG_CYC     16'h0190
`define RSQ_TRST_CYC    16'h0050
`define RSQ_FRC_CYC     16'h0028
`define RSQ_LPRC_CYC    16'h00C8
`define RSQ_CLOCK_FAIL_MONITOR_CYC    16'h0028
`define RSQ_OST_LAST    10'h3FF
`define RSQ_OSC_FRC     3'h0
`define RSQ_OSC_FRCPLL  3'h1
`define RSQ_OSC_PRI     3'h2
`define RSQ_OSC_PRIPLL  3'h3
`define RSQ_OSC_SOSC    3'h4
`define RSQ_OSC_LPRC    3'h5
`define RSQ_OSC_FRCDIV  3'h7
`endif

// *** rsq_top.v ***
// Reset cause flags, master reset release sequencing and clock source selection.
`timescale 1ns/100ps
// Notes on behaviour
// - Watchdog on by soft bit or config.
// - Timeout flag; cleared by clear, power-save, POR.
// - Power-save operand 0 sets sleep flag.
// - Power-save operand 1 sets idle flag.
// - Sleep with deep-sleep enable sets deep flag.
// - Brown-out flag set by brown-out and POR.
// - Core power-on sets power-on flag.
// - Each reset source sets its own flag.
// - Software writes flags freely, never resets.
// - Supply flags hardware set, software clear-only.
// - Supply brown-out flag, power-on value one.
// - Supply power-on flag separate from core.
// - Battery power-on flag on low battery, power-up.
// - Battery flag set on power-on exit.
// - Only cause, osc, flash reset differ.
// - POR holds power-on, regulator, state delays.
// - Brown-out regulator plus state; others state only.
// - Oscillator start-up counts 1024 periods.
// - Clock waits concurrent; code waits for both.
// - Switching on: POR/BOR config, others keep.
// - Switching off: always config selection.
// - Two-speed starts fast RC, then primary.
// - Enabled brown-out detect causes brown-out reset.
// - Clock monitor starts after release plus delay.
// - POR clears flags except brown-out, power-on.
// - Any reset source asserts master reset.
`include "rsq_map.vh"

module rsq_top #(
	parameter [15:0] POR_CYC  = `RSQ_POR_CYC,
	parameter [15:0] REG_CYC  = `RSQ_REG_CYC,
	parameter [15:0] TRST_CYC = `RSQ_TRST_CYC,
	parameter [15:0] FRC_CYC  = `RSQ_FRC_CYC,
	parameter [15:0] LPRC_CYC = `RSQ_LPRC_CYC,
	parameter [15:0] CLOCK_FAIL_MONITOR_CYC = `RSQ_CLOCK_FAIL_MONITOR_CYC
) (
	input  wire        SYS_CLK,
	input  wire        SYS_RST,
	input  wire        PSEL,
	input  wire        PENABLE,
	input  wire        PWRITE,
	input  wire [11:0] PADDR,
	input  wire [31:0] PWDATA,
	output reg  [31:0] PRDATA,
	output wire        PREADY,
	output wire        PSLVERR,
	input  wire        SUPPLY_POR_EVENT,
	input  wire        BROWNOUT_DETECT,
	input  wire        BROWNOUT_ENABLE_CONFIG,
	input  wire        PIN_RESET,
	input  wire        WATCHDOG_TIMEOUT,
	input  wire        RESET_INSTR,
	input  wire        TRAP_CONFLICT,
	input  wire        ILLEGAL_OP,
	input  wire        CONFIG_MISMATCH,
	input  wire        WATCHDOG_CLEAR_INSTR,
	input  wire        POWER_SAVE_INSTR,
	input  wire        POWER_SAVE_OPERAND,
	input  wire        DEEP_SLEEP_ENABLE,
	input  wire        BATTERY_PRESENT,
	input  wire        BATTERY_LOW,
	input  wire        WATCHDOG_CONFIG_ENABLE,
	input  wire        CLOCK_SWITCH_ENABLE,
	input  wire        TWO_SPEED_ENABLE,
	input  wire [2:0]  CONFIG_OSC_SELECT,
	input  wire        PRIMARY_IS_CRYSTAL,
	input  wire        OSC_TICK,
	input  wire        PLL_LOCKED,
	input  wire        CLOCK_FAIL_MONITOR_ENABLE,
	output wire        MASTER_SYSTEM_RESET,
	output wire        FLASH_CTRL_RESET,
	output wire        WATCHDOG_ENABLE,
	output reg         CODE_RUN_ENABLE,
	output reg         CLOCK_FAIL_MONITOR_ACTIVE,
	output wire [2:0]  CURRENT_OSC_SELECT
);

	localparam [2:0] S_HOLD = 3'h0;
	localparam [2:0] S_POR  = 3'h1;
	localparam [2:0] S_REG  = 3'h2;
	localparam [2:0] S_RST  = 3'h3;
	localparam [2:0] S_RUN  = 3'h4;
	localparam [1:0] K_SHORT = 2'h0;
	localparam [1:0] K_BOR   = 2'h1;
	localparam [1:0] K_POR   = 2'h2;

	reg  [2:0]  state;
	reg  [1:0]  kind;
	reg  [15:0] cnt;
	reg  [15:0] cause;
	reg  [3:0]  supply;
	reg  [15:0] next_cause;
	reg  [3:0]  next_supply;
	reg  [2:0]  cur_osc;
	reg  [2:0]  tgt_osc;
	reg  [9:0]  ost_cnt;
	reg         ost_done;
	reg  [15:0] rc_cnt;
	reg  [15:0] clock_fail_monitor_cnt;
	reg  [2:0]  sel_osc;
	reg  [1:0]  new_kind;

	wire        bor_src;
	wire        short_src;
	wire        any_src;
	wire        accept;
	wire        por_exit;
	wire [1:0]  rsel;
	wire        acc;
	wire        wr_cause;
	wire        wr_supply;
	wire        ps_sleep;
	wire        ps_idle;

	// ----------------------------------------------------------------
	// Register decode
	// ----------------------------------------------------------------
	function [1:0] reg_sel;
		input [11:0] addr;
		begin
			case (addr)
				`RSQ_OFS_CAUSE:  reg_sel = 2'h1;
				`RSQ_OFS_SUPPLY: reg_sel = 2'h2;
				`RSQ_OFS_STATUS: reg_sel = 2'h3;
				default:         reg_sel = 2'h0;
			endcase
		end
	endfunction

	// True once the named clock source has finished its start-up wait.
	function src_ready;
		input [2:0] code;
		begin
			case (code)
				`RSQ_OSC_FRC, `RSQ_OSC_FRCDIV: src_ready = rc_cnt >= FRC_CYC;
				`RSQ_OSC_FRCPLL: src_ready = (rc_cnt >= FRC_CYC) & PLL_LOCKED;
				`RSQ_OSC_PRI:    src_ready = ost_done | ~PRIMARY_IS_CRYSTAL;
				`RSQ_OSC_PRIPLL: src_ready = (ost_done | ~PRIMARY_IS_CRYSTAL) & PLL_LOCKED;
				`RSQ_OSC_SOSC:   src_ready = ost_done;
				`RSQ_OSC_LPRC:   src_ready = rc_cnt >= LPRC_CYC;
				default:         src_ready = 1'b1;
			endcase
		end
	endfunction

	function is_primary;
		input [2:0] code;
		begin
			is_primary = (code == `RSQ_OSC_PRI) | (code == `RSQ_OSC_PRIPLL) | (code == `RSQ_OSC_SOSC);
		end
	endfunction

	// ----------------------------------------------------------------
	// Reset sources
	// ----------------------------------------------------------------
	assign bor_src   = BROWNOUT_DETECT & BROWNOUT_ENABLE_CONFIG;
	assign short_src = PIN_RESET | WATCHDOG_TIMEOUT | RESET_INSTR | TRAP_CONFLICT | ILLEGAL_OP | CONFIG_MISMATCH;
	assign any_src   = SUPPLY_POR_EVENT | bor_src | short_src;
	assign accept    = (state == S_HOLD) & ~any_src;
	assign por_exit  = (state == S_RST) & (cnt == 16'h0000) & (kind == K_POR) & ~any_src;
	assign ps_sleep  = POWER_SAVE_INSTR & ~POWER_SAVE_OPERAND;
	assign ps_idle   = POWER_SAVE_INSTR & POWER_SAVE_OPERAND;

	always @* begin
		if (SUPPLY_POR_EVENT) begin
			new_kind = K_POR;
		end else if (bor_src) begin
			new_kind = K_BOR;
		end else begin
			new_kind = K_SHORT;
		end
	end

	// ----------------------------------------------------------------
	// Master reset sequencer
	// ----------------------------------------------------------------
	// A source that stays active keeps the sequence in hold; the delays
	// count from its release, so a long pin reset stretches the hold.
	always @(posedge SYS_CLK) begin
		if (SYS_RST) begin
			state <= S_HOLD;
			kind  <= K_POR;
			cnt   <= 16'h0000;
		end else if (any_src) begin
			state <= S_HOLD;
			if (state == S_RUN || new_kind > kind) begin
				kind <= new_kind;
			end
		end else begin
			case (state)
				S_HOLD: begin
					if (kind == K_POR) begin
						state <= S_POR;
						cnt   <= POR_CYC - 16'h0001;
					end else if (kind == K_BOR) begin
						state <= S_REG;
						cnt   <= REG_CYC - 16'h0001;
					end else begin
						state <= S_RST;
						cnt   <= TRST_CYC - 16'h0001;
					end
				end
				S_POR: begin
					if (cnt == 16'h0000) begin
						state <= S_REG;
						cnt   <= REG_CYC - 16'h0001;
					end else begin
						cnt <= cnt - 16'h0001;
					end
				end
				S_REG: begin
					if (cnt == 16'h0000) begin
						state <= S_RST;
						cnt   <= TRST_CYC - 16'h0001;
					end else begin
						cnt <= cnt - 16'h0001;
					end
				end
				S_RST: begin
					if (cnt == 16'h0000) begin
						state <= S_RUN;
					end else begin
						cnt <= cnt - 16'h0001;
					end
				end
				S_RUN: state <= S_RUN;
				default: state <= S_RUN;
			endcase
		end
	end

	assign MASTER_SYSTEM_RESET = state != S_RUN;
	// Flash control is cleared by power-on type sequences only.
	assign FLASH_CTRL_RESET = (state != S_RUN) & (kind == K_POR);

	// ----------------------------------------------------------------
	// Reset cause flags
	// ----------------------------------------------------------------
	// Order is software write, hardware clear, hardware set, so an event
	// landing in the same cycle as a clear is never lost.
	always @* begin
		next_cause = cause;
		if (wr_cause) begin
			next_cause = PWDATA[15:0] & `RSQ_CAUSE_WMASK;
		end
		if (WATCHDOG_CLEAR_INSTR | POWER_SAVE_INSTR) begin
			next_cause[`RSQ_B_WATCHDOG_TIMEOUT_FLAG] = 1'b0;
		end
		if (WATCHDOG_TIMEOUT) begin
			next_cause[`RSQ_B_WATCHDOG_TIMEOUT_FLAG] = 1'b1;
		end
		if (ps_sleep) begin
			next_cause[`RSQ_B_SLEEP] = 1'b1;
		end
		if (ps_sleep & DEEP_SLEEP_ENABLE) begin
			next_cause[`RSQ_B_DSLP] = 1'b1;
		end
		if (ps_idle) begin
			next_cause[`RSQ_B_IDLE] = 1'b1;
		end
		if (bor_src) begin
			next_cause[`RSQ_B_BOR] = 1'b1;
		end
		if (TRAP_CONFLICT) begin
			next_cause[`RSQ_B_TRAP] = 1'b1;
		end
		if (ILLEGAL_OP) begin
			next_cause[`RSQ_B_ILLOP] = 1'b1;
		end
		if (CONFIG_MISMATCH) begin
			next_cause[`RSQ_B_CM] = 1'b1;
		end
		if (PIN_RESET) begin
			next_cause[`RSQ_B_PIN] = 1'b1;
		end
		if (RESET_INSTR) begin
			next_cause[`RSQ_B_SWR] = 1'b1;
		end
	end

	// Clear-only from software: a written one leaves the flag as it is.
	always @* begin
		next_supply = supply;
		if (wr_supply) begin
			next_supply = supply & PWDATA[3:0];
		end
		if (bor_src) begin
			next_supply[`RSQ_B_SBOR] = 1'b1;
		end
		if (SUPPLY_POR_EVENT) begin
			next_supply[`RSQ_B_SPOR] = 1'b1;
		end
		if (BATTERY_LOW) begin
			next_supply[`RSQ_B_BPOR] = 1'b1;
		end
		if (por_exit & BATTERY_PRESENT) begin
			next_supply[`RSQ_B_BAT] = 1'b1;
		end
	end

	always @(posedge SYS_CLK) begin
		if (SYS_RST) begin
			cause  <= `RSQ_CAUSE_RST;
			supply <= `RSQ_SUPPLY_RST;
		end else begin
			cause  <= next_cause;
			supply <= next_supply;
		end
	end

	assign WATCHDOG_ENABLE = WATCHDOG_CONFIG_ENABLE | cause[`RSQ_B_SW_WATCHDOG_ENABLE];

	// ----------------------------------------------------------------
	// Clock source selection and start-up timers
	// ----------------------------------------------------------------
	always @* begin
		if (kind != K_SHORT || !CLOCK_SWITCH_ENABLE) begin
			sel_osc = CONFIG_OSC_SELECT;
		end else begin
			sel_osc = cur_osc;
		end
	end

	// Timers restart as the sequence leaves hold and run while the master
	// reset delays count, so the two waits overlap.
	always @(posedge SYS_CLK) begin
		if (SYS_RST) begin
			cur_osc  <= `RSQ_OSC_FRC;
			tgt_osc  <= `RSQ_OSC_FRC;
			ost_cnt  <= 10'h000;
			ost_done <= 1'b0;
			rc_cnt   <= 16'h0000;
		end else if (accept) begin
			ost_cnt  <= 10'h000;
			ost_done <= 1'b0;
			rc_cnt   <= 16'h0000;
			tgt_osc  <= sel_osc;
			if (TWO_SPEED_ENABLE && is_primary(sel_osc)) begin
				cur_osc <= `RSQ_OSC_FRC;
			end else begin
				cur_osc <= sel_osc;
			end
		end else begin
			if (rc_cnt != 16'hFFFF) begin
				rc_cnt <= rc_cnt + 16'h0001;
			end
			if (OSC_TICK && !ost_done) begin
				if (ost_cnt == `RSQ_OST_LAST) begin
					ost_done <= 1'b1;
				end else begin
					ost_cnt <= ost_cnt + 10'h001;
				end
			end
			if (state != S_HOLD && cur_osc != tgt_osc && src_ready(tgt_osc)) begin
				cur_osc <= tgt_osc;
			end
		end
	end

	assign CURRENT_OSC_SELECT = cur_osc;

	always @(posedge SYS_CLK) begin
		if (SYS_RST) begin
			CODE_RUN_ENABLE           <= 1'b0;
			CLOCK_FAIL_MONITOR_ACTIVE <= 1'b0;
			clock_fail_monitor_cnt                  <= 16'h0000;
		end else begin
			CODE_RUN_ENABLE <= (state == S_RUN) & ~any_src & src_ready(cur_osc);
			if (state != S_RUN) begin
				clock_fail_monitor_cnt                  <= 16'h0000;
				CLOCK_FAIL_MONITOR_ACTIVE <= 1'b0;
			end else begin
				if (clock_fail_monitor_cnt != 16'hFFFF) begin
					clock_fail_monitor_cnt <= clock_fail_monitor_cnt + 16'h0001;
				end
				CLOCK_FAIL_MONITOR_ACTIVE <= CLOCK_FAIL_MONITOR_ENABLE & (clock_fail_monitor_cnt >= CLOCK_FAIL_MONITOR_CYC);
			end
		end
	end

	// ----------------------------------------------------------------
	// APB slave
	// ----------------------------------------------------------------
	// Zero wait states: read data is captured in the setup cycle.
	assign rsel      = reg_sel(PADDR);
	assign acc       = PSEL & PENABLE;
	assign wr_cause  = acc & PWRITE & (rsel == 2'h1);
	assign wr_supply = acc & PWRITE & (rsel == 2'h2);
	assign PREADY    = 1'b1;
	assign PSLVERR   = acc & (rsel == 2'h0);

	always @(posedge SYS_CLK) begin
		if (SYS_RST) begin
			PRDATA <= 32'h00000000;
		end else if (PSEL && !PENABLE && !PWRITE) begin
			case (rsel)
				2'h1: PRDATA <= {16'h0000, cause};
				2'h2: PRDATA <= {28'h0000000, supply};
				2'h3: PRDATA <= {21'h000000, CLOCK_FAIL_MONITOR_ACTIVE, CODE_RUN_ENABLE,
					MASTER_SYSTEM_RESET, kind, tgt_osc, cur_osc};
				default: PRDATA <= 32'h00000000;
			endcase
		end
	end

endmodule // rsq_top

// *** rsq_top_props.sv ***
// Concurrent checks on the ports of the reset sequencer.
`timescale 1ns/100ps
module rsq_top_props #(
	parameter int TRST_CYC = 2
) (
	input logic        SYS_CLK,
	input logic        SYS_RST,
	input logic        PSEL,
	input logic        PENABLE,
	input logic [11:0] PADDR,
	input logic        PSLVERR,
	input logic        SUPPLY_POR_EVENT,
	input logic        BROWNOUT_DETECT,
	input logic        BROWNOUT_ENABLE_CONFIG,
	input logic        PIN_RESET,
	input logic        WATCHDOG_TIMEOUT,
	input logic        RESET_INSTR,
	input logic        TRAP_CONFLICT,
	input logic        ILLEGAL_OP,
	input logic        CONFIG_MISMATCH,
	input logic        WATCHDOG_CONFIG_ENABLE,
	input logic        MASTER_SYSTEM_RESET,
	input logic        FLASH_CTRL_RESET,
	input logic        WATCHDOG_ENABLE,
	input logic        CODE_RUN_ENABLE,
	input logic        CLOCK_FAIL_MONITOR_ACTIVE
);
	wire short_src = WATCHDOG_TIMEOUT | RESET_INSTR | TRAP_CONFLICT | ILLEGAL_OP | CONFIG_MISMATCH;
	wire long_src  = SUPPLY_POR_EVENT | (BROWNOUT_DETECT & BROWNOUT_ENABLE_CONFIG);
	// A lone pin pulse from the running state; a power-on or brown-out source would lengthen the hold.
	wire pin_alone = PIN_RESET & ~short_src & ~long_src & ~MASTER_SYSTEM_RESET;
	default clocking @(posedge SYS_CLK); endclocking
	default disable iff (SYS_RST);
	a_any_source: assert property ((PIN_RESET | short_src | long_src) |=> MASTER_SYSTEM_RESET)
		else $error("reset source did not hold master reset");
	a_pin_release: assert property (pin_alone ##1 !PIN_RESET |->
		MASTER_SYSTEM_RESET ##TRST_CYC MASTER_SYSTEM_RESET ##1 !MASTER_SYSTEM_RESET) else $error("pin hold length");
	a_pin_no_flash: assert property (pin_alone |=> !FLASH_CTRL_RESET)
		else $error("flash reset on pin reset");
	a_por_flash: assert property (SUPPLY_POR_EVENT |=> FLASH_CTRL_RESET && MASTER_SYSTEM_RESET)
		else $error("flash reset missing on power-on");
	a_run_gate: assert property (CODE_RUN_ENABLE |-> !MASTER_SYSTEM_RESET)
		else $error("code runs under reset");
	a_mon_late: assert property ($rose(CLOCK_FAIL_MONITOR_ACTIVE) |-> !$past(MASTER_SYSTEM_RESET))
		else $error("monitor started early");
	a_wdt_forced: assert property (WATCHDOG_CONFIG_ENABLE |-> WATCHDOG_ENABLE)
		else $error("watchdog not forced on");
	a_unmapped_err: assert property (PSEL && PENABLE && PADDR > 12'h008 |-> PSLVERR)
		else $error("unmapped access not refused");
	c_pin: cover property (pin_alone);
	c_run: cover property ($rose(CODE_RUN_ENABLE));
	c_mon: cover property ($rose(CLOCK_FAIL_MONITOR_ACTIVE));
endmodule // rsq_top_props

// *** rsq_osc_model.sv ***
// Behavioural oscillator and PLL seen by the sequencer.
`timescale 1ns/100ps
module rsq_osc_model (
	input  wire  clk,
	input  wire  rst,
	input  wire  slow,
	input  wire  msr,
	output logic tick,
	output logic lock
);
	logic [3:0] cnt;
	// The PLL loses lock under every reset, so the sequencer must really wait for it.
	always @(posedge clk) begin
		tick <= rst ? 1'b0 : (slow ? ~tick : 1'b1);
		cnt  <= (rst | msr) ? 4'h0 : cnt + {3'h0, ~lock};
		lock <= (cnt == 4'h8);
	end
endmodule // rsq_osc_model

// *** rsq_top_tb.sv ***
// Self-checking testbench for the reset sequencer.
`timescale 1ns/100ps
`include "rsq_map.vh"
module rsq_top_tb;
	logic        SYS_CLK = '0, SYS_RST = 1'b1, PSEL = '0, PENABLE = '0, PWRITE = '0;
	logic [11:0] PADDR = '0;
	logic [31:0] PWDATA = '0, rd;
	logic [7:0]  src = '0;
	logic        wclr = '0, ps = '0, psop = '0, deep_sleep_enable = '0, blow = '0, wcfg = '0, cse = '0, tse = '0, slow = '0, slverr;
	logic [2:0]  cfg = '0;
	logic        brownout_enable_config = 1'b1, bpres = 1'b1, xtal = 1'b1, men = 1'b1;
	wire  [31:0] PRDATA;
	wire         PREADY, PSLVERR, msr, wen, run, mon, tick, lock, flash;
	wire  [2:0]  osc;
	int          err_total = 0, compares = 0;
	rsq_top #(.POR_CYC(16'h0004), .REG_CYC(16'h0003), .TRST_CYC(16'h0002), .FRC_CYC(16'h0002))
		dut (.SYS_CLK, .SYS_RST, .PSEL, .PENABLE, .PWRITE, .PADDR,
		.PWDATA, .PRDATA, .PREADY, .PSLVERR, .SUPPLY_POR_EVENT(src[7]), .BROWNOUT_DETECT(src[6]),
		.BROWNOUT_ENABLE_CONFIG(brownout_enable_config), .PIN_RESET(src[0]), .WATCHDOG_TIMEOUT(src[1]), .RESET_INSTR(src[2]),
		.TRAP_CONFLICT(src[3]), .ILLEGAL_OP(src[4]), .CONFIG_MISMATCH(src[5]), .WATCHDOG_CLEAR_INSTR(wclr),
		.POWER_SAVE_INSTR(ps), .POWER_SAVE_OPERAND(psop), .DEEP_SLEEP_ENABLE(deep_sleep_enable), .BATTERY_PRESENT(bpres),
		.BATTERY_LOW(blow), .WATCHDOG_CONFIG_ENABLE(wcfg), .CLOCK_SWITCH_ENABLE(cse), .TWO_SPEED_ENABLE(tse),
		.CONFIG_OSC_SELECT(cfg), .PRIMARY_IS_CRYSTAL(xtal), .OSC_TICK(tick), .PLL_LOCKED(lock),
		.CLOCK_FAIL_MONITOR_ENABLE(men), .MASTER_SYSTEM_RESET(msr), .FLASH_CTRL_RESET(flash),
		.WATCHDOG_ENABLE(wen), .CODE_RUN_ENABLE(run), .CLOCK_FAIL_MONITOR_ACTIVE(mon), .CURRENT_OSC_SELECT(osc));
	rsq_osc_model u_osc (.clk(SYS_CLK), .rst(SYS_RST), .slow, .msr, .tick, .lock);
	// ----------------------------------------
	// Shared bus and compare tasks
	// ----------------------------------------
	task chk(input [31:0] got, input [31:0] exp);
		compares++;
		if (got !== exp) begin
			err_total++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task chk1(input logic got, input logic exp);
		chk({31'h0, got}, {31'h0, exp});
	endtask
	task apb(input w, input [11:0] a, input [31:0] d);
		@(posedge SYS_CLK);
		PSEL <= 1'b1;
		PWRITE <= w;
		PADDR <= a;
		PWDATA <= d;
		@(posedge SYS_CLK);
		PENABLE <= 1'b1;
		do @(posedge SYS_CLK); while (PREADY !== 1'b1);
		rd = PRDATA;
		slverr = PSLVERR;
		PSEL <= 1'b0;
		PENABLE <= 1'b0;
	endtask
	// Pulses one source for a cycle and counts the cycles the master reset stays high.
	task pulse(input int i, input int len);
		int n;
		n = 0;
		@(posedge SYS_CLK) src[i] <= 1'b1;
		@(posedge SYS_CLK) src[i] <= 1'b0;
		@(negedge SYS_CLK);
		while (msr === 1'b1 && n < 5000) begin
			n++;
			@(negedge SYS_CLK);
		end
		chk(n, len);
	endtask
	task wait_run(output int n);
		n = 0;
		while (run !== 1'b1 && n < 3000) begin
			@(negedge SYS_CLK);
			n++;
		end
		chk1(run, 1'b1);
		@(posedge SYS_CLK);
	endtask
	task psave(input logic op);
		@(posedge SYS_CLK) ps <= 1'b1;
		psop <= op;
		@(posedge SYS_CLK) ps <= 1'b0;
		apb(0, `RSQ_OFS_CAUSE, 32'h0);
	endtask
	task finish_test;
		$display("compares %0d mismatches %0d", compares, err_total);
		if (err_total == 0 && compares > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task t_por;
		int n;
		apb(0, `RSQ_OFS_SUPPLY, 32'h0);
		chk(rd, 32'h000E);
		chk1(msr, 1'b1);
		chk1(flash, 1'b1);
		wait_run(n);
		chk1(mon, 1'b0);
		chk1(flash, 1'b0);
		apb(0, `RSQ_OFS_CAUSE, 32'h0);
		chk(rd, 32'h0003);
		apb(0, `RSQ_OFS_SUPPLY, 32'h0);
		chk(rd, 32'h000F);
		chk({29'h0, osc}, `RSQ_OSC_FRC);
		repeat (40) @(posedge SYS_CLK);
		chk1(mon, 1'b1);
		$display("t_por done");
	endtask
	task t_regs;
		apb(1, `RSQ_OFS_CAUSE, 32'hFFFF);
		@(negedge SYS_CLK) chk1(msr, 1'b0);
		apb(0, `RSQ_OFS_CAUSE, 32'h0);
		chk(rd, 32'hD7FF);
		chk1(wen, 1'b1);
		apb(1, `RSQ_OFS_CAUSE, 32'h0);
		apb(0, `RSQ_OFS_CAUSE, 32'h0);
		chk(rd, 32'h0);
		chk1(wen, 1'b0);
		wcfg <= 1'b1;
		@(negedge SYS_CLK) chk1(wen, 1'b1);
		apb(1, `RSQ_OFS_SUPPLY, 32'h0);
		apb(1, `RSQ_OFS_SUPPLY, 32'hF);
		apb(0, `RSQ_OFS_SUPPLY, 32'h0);
		chk(rd, 32'h0);
		blow <= 1'b1;
		@(posedge SYS_CLK) blow <= 1'b0;
		apb(0, `RSQ_OFS_SUPPLY, 32'h0);
		chk(rd, 32'h0002);
		apb(0, 12'h00C, 32'h0);
		chk1(slverr, 1'b1);
		chk(rd, 32'h0);
		$display("t_regs done");
	endtask
	task t_events;
		int bitpos[6] = '{7, 4, 6, 15, 14, 9};
		int n;
		apb(1, `RSQ_OFS_SUPPLY, 32'h0);
		for (int i = 0; i < 6; i++) begin
			pulse(i, 3);
			wait_run(n);
			apb(0, `RSQ_OFS_CAUSE, 32'h0);
			chk(rd, 32'h1 << bitpos[i]);
			apb(1, `RSQ_OFS_CAUSE, 32'h0);
		end
		$display("t_events done");
	endtask
	task t_save;
		apb(1, `RSQ_OFS_CAUSE, 32'h0010);
		@(posedge SYS_CLK) wclr <= 1'b1;
		@(posedge SYS_CLK) wclr <= 1'b0;
		apb(0, `RSQ_OFS_CAUSE, 32'h0);
		chk(rd, 32'h0);
		apb(1, `RSQ_OFS_CAUSE, 32'h0010);
		deep_sleep_enable <= 1'b1;
		psave(1'b0);
		chk(rd, 32'h0408);
		psave(1'b1);
		chk(rd, 32'h040C);
		apb(1, `RSQ_OFS_CAUSE, 32'h0);
		$display("t_save done");
	endtask
	task t_bor;
		int n;
		brownout_enable_config <= 1'b0;
		pulse(6, 0);
		apb(0, `RSQ_OFS_CAUSE, 32'h0);
		chk(rd, 32'h0);
		brownout_enable_config <= 1'b1;
		pulse(6, 6);
		wait_run(n);
		apb(0, `RSQ_OFS_CAUSE, 32'h0);
		chk(rd, 32'h0002);
		apb(0, `RSQ_OFS_SUPPLY, 32'h0);
		chk(rd, 32'h0008);
		apb(1, `RSQ_OFS_CAUSE, 32'h0);
		apb(1, `RSQ_OFS_SUPPLY, 32'h0);
		pulse(7, 10);
		wait_run(n);
		apb(0, `RSQ_OFS_SUPPLY, 32'h0);
		chk(rd & 32'h4, 32'h4);
		apb(0, `RSQ_OFS_CAUSE, 32'h0);
		chk(rd & 32'h1, 32'h0);
		$display("t_bor done");
	endtask
	task t_osc;
		int n;
		cse <= 1'b1;
		cfg <= `RSQ_OSC_PRI;
		pulse(6, 6);
		wait_run(n);
		chk1(n > 900, 1'b1);
		chk({29'h0, osc}, `RSQ_OSC_PRI);
		cfg <= `RSQ_OSC_FRC;
		pulse(0, 3);
		wait_run(n);
		chk({29'h0, osc}, `RSQ_OSC_PRI);
		cse <= 1'b0;
		pulse(0, 3);
		wait_run(n);
		chk({29'h0, osc}, `RSQ_OSC_FRC);
		cse <= 1'b1;
		tse <= 1'b1;
		slow <= 1'b1;
		cfg <= `RSQ_OSC_PRI;
		pulse(6, 6);
		wait_run(n);
		chk1(n < 50, 1'b1);
		chk({29'h0, osc}, `RSQ_OSC_FRC);
		repeat (2200) @(posedge SYS_CLK);
		chk({29'h0, osc}, `RSQ_OSC_PRI);
		cse <= 1'b0;
		cfg <= `RSQ_OSC_FRCPLL;
		pulse(0, 3);
		wait_run(n);
		chk1(n > 7, 1'b1);
		chk({29'h0, osc}, `RSQ_OSC_FRCPLL);
		$display("t_osc done");
	endtask
	initial begin
		forever #12.5 SYS_CLK = ~SYS_CLK;
	end
	initial begin
		repeat (5) @(posedge SYS_CLK);
		SYS_RST <= 1'b0;
		t_por();
		t_regs();
		t_events();
		t_save();
		t_bor();
		t_osc();
		finish_test();
	end
	initial begin
		#(25 * 40000);
		err_total++;
		finish_test();
	end
endmodule // rsq_top_tb
bind rsq_top rsq_top_props #(.TRST_CYC(TRST_CYC)) u_props (.*);
